// File: rtl/input_change_detect_and_reset.v
// input transition detection, latched alert, strap defaults and serial slave front end
`timescale 1ns/100ps
`include "input_change_detect_and_reset_defs.vh"
module input_change_detect_and_reset
(
  input  wire       i_clk,
  input  wire       i_arst_n,
  input  wire       i_scl,
  input  wire       i_sda,
  output reg        o_sda_out,
  output reg        o_sda_oe,
  input  wire       i_bus_abort_n,
  input  wire [3:0] i_in,
  input  wire       i_addr_strap_low,
  input  wire       i_addr_strap_high,
  output reg        o_int_n,
  output reg  [3:0] o_flags,
  output reg  [3:0] o_mask,
  output reg  [3:0] o_pullup_en,
  output reg  [3:0] o_out_default,
  output reg  [6:0] o_addr,
  output reg        o_standby
);

  localparam [6:0] ST_IDLE  = 7'h01;
  localparam [6:0] ST_ADDR  = 7'h02;
  localparam [6:0] ST_AACK  = 7'h04;
  localparam [6:0] ST_WDATA = 7'h08;
  localparam [6:0] ST_WACK  = 7'h10;
  localparam [6:0] ST_RDATA = 7'h20;
  localparam [6:0] ST_RACK  = 7'h40;

  // strap class tied to anything but ground selects pullup and default high
  function is_high_class;
    input [1:0] cls;
    begin
      is_high_class = (cls != `CLS_GND);
    end
  endfunction

  reg  [`SYNC_W-1:0] sync1_ff;
  reg  [`SYNC_W-1:0] sync2_ff;
  reg                scl_prev_ff;
  reg                sda_prev_ff;
  reg  [1:0]         settle_ff;
  reg  [6:0]         state_ff;
  reg  [2:0]         bit_ff;
  reg                done_ff;
  reg  [7:0]         rx_ff;
  reg  [7:0]         tx_ff;
  reg                rd_ff;
  reg  [3:0]         ref_ff;
  reg  [3:0]         in_prev_ff;
  reg  [7:0]         mask_ff;
  reg  [3:0]         flag_ff;
  reg                access_ff;

  wire               scl_s;
  wire               sda_s;
  wire               abort_s;
  wire [3:0]         in_s;
  wire               strap_lo_s;
  wire               strap_hi_s;
  wire               settled;
  wire               scl_rise;
  wire               scl_fall;
  wire               start_cond;
  wire               stop_cond;
  wire [1:0]         cls_lo;
  wire [1:0]         cls_hi;
  wire [6:0]         own_addr;
  wire [3:0]         mask4;
  wire [3:0]         change;
  wire [3:0]         edge_now;
  wire [7:0]         rd_byte;

  reg  [3:0]         nxt_flag;
  reg  [3:0]         nxt_ref;

  assign scl_s      = sync2_ff[0];
  assign sda_s      = sync2_ff[1];
  assign abort_s    = ~sync2_ff[2];
  assign in_s       = sync2_ff[6:3];
  assign strap_lo_s = sync2_ff[7];
  assign strap_hi_s = sync2_ff[8];
  assign settled    = (settle_ff == `SETTLE_MAX);
  assign scl_rise   = scl_s & ~scl_prev_ff;
  assign scl_fall   = ~scl_s & scl_prev_ff;
  assign start_cond = scl_s & scl_prev_ff & sda_prev_ff & ~sda_s;
  assign stop_cond  = scl_s & scl_prev_ff & ~sda_prev_ff & sda_s;
  assign own_addr   = {`ADDR_TOP, cls_hi ^ `AD2_XOR, cls_lo};
  assign mask4      = mask_ff[`IN_MSB:`IN_LSB];
  assign change     = in_s ^ ref_ff;
  assign edge_now   = in_s ^ in_prev_ff;
  // flags of I5,I4 on top, live levels in the mask positions, flags of I3,I2 below
  assign rd_byte    = {flag_ff[3:2], in_s, flag_ff[1:0]};

  // pins cross into this domain through two flops before anything reads them
  always @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      sync1_ff    <= `SYNC_RST;
      sync2_ff    <= `SYNC_RST;
      scl_prev_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
      settle_ff   <= 2'h0;
      in_prev_ff  <= 4'h0;
    end
    else
    begin
      sync1_ff    <= {i_addr_strap_high, i_addr_strap_low, i_in, i_bus_abort_n, i_sda, i_scl};
      sync2_ff    <= sync1_ff;
      scl_prev_ff <= scl_s;
      sda_prev_ff <= sda_s;
      in_prev_ff  <= in_s;
      if (!settled)
        settle_ff <= settle_ff + 2'h1;
    end
  end

  strap_decode u_strap_low
  (
    .i_clk     (i_clk),
    .i_arst_n  (i_arst_n),
    .i_strap   (strap_lo_s),
    .i_scl     (scl_s),
    .i_sda     (sda_s),
    .i_settled (settled),
    .i_start   (start_cond),
    .i_stop    (stop_cond),
    .o_cls_ff  (cls_lo)
  );

  strap_decode u_strap_high
  (
    .i_clk     (i_clk),
    .i_arst_n  (i_arst_n),
    .i_strap   (strap_hi_s),
    .i_scl     (scl_s),
    .i_sda     (sda_s),
    .i_settled (settled),
    .i_start   (start_cond),
    .i_stop    (stop_cond),
    .o_cls_ff  (cls_hi)
  );

  // serial slave; the abort only touches this process, never the alert
  always @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      state_ff  <= ST_IDLE;
      bit_ff    <= `BIT_ZERO;
      done_ff   <= 1'b0;
      rx_ff     <= `BYTE_ZERO;
      tx_ff     <= `BYTE_ZERO;
      rd_ff     <= 1'b0;
      o_sda_oe  <= 1'b0;
      o_sda_out <= 1'b0;
      access_ff <= 1'b0;
      mask_ff   <= `MASK_ALL;
    end
    else
    begin
      access_ff <= 1'b0;
      o_sda_out <= 1'b0;
      if (abort_s || !settled)
      begin
        state_ff <= ST_IDLE;
        o_sda_oe <= 1'b0;
        done_ff  <= 1'b0;
      end
      else if (stop_cond)
      begin
        state_ff <= ST_IDLE;
        o_sda_oe <= 1'b0;
      end
      else if (start_cond)
      begin
        state_ff <= ST_ADDR;
        bit_ff   <= `BIT_ZERO;
        done_ff  <= 1'b0;
        o_sda_oe <= 1'b0;
      end
      else
      begin
        if (scl_rise && (state_ff == ST_ADDR || state_ff == ST_WDATA))
        begin
          rx_ff   <= {rx_ff[6:0], sda_s};
          bit_ff  <= bit_ff + `BIT_ONE;
          done_ff <= (bit_ff == `BIT_LAST);
        end
        if (scl_rise && state_ff == ST_RDATA)
        begin
          bit_ff  <= bit_ff + `BIT_ONE;
          done_ff <= (bit_ff == `BIT_LAST);
        end
        case (state_ff)
          ST_IDLE:
            o_sda_oe <= 1'b0;
          ST_ADDR:
            if (scl_fall && done_ff)
            begin
              done_ff <= 1'b0;
              if (rx_ff[7:1] == own_addr)
              begin
                state_ff  <= ST_AACK;
                rd_ff     <= rx_ff[0];
                o_sda_oe  <= 1'b1;
                access_ff <= 1'b1;
              end
              else
                state_ff <= ST_IDLE;
            end
          ST_AACK, ST_WACK:
            if (scl_fall)
            begin
              if (rd_ff)
              begin
                state_ff <= ST_RDATA;
                tx_ff    <= {rd_byte[6:0], 1'b0};
                o_sda_oe <= ~rd_byte[7];
              end
              else
              begin
                state_ff <= ST_WDATA;
                o_sda_oe <= 1'b0;
              end
            end
          ST_WDATA:
            if (scl_fall && done_ff)
            begin
              done_ff  <= 1'b0;
              mask_ff  <= rx_ff & `MASK_ALL;
              state_ff <= ST_WACK;
              o_sda_oe <= 1'b1;
            end
          ST_RDATA:
            if (scl_fall)
            begin
              if (done_ff)
              begin
                done_ff  <= 1'b0;
                state_ff <= ST_RACK;
                o_sda_oe <= 1'b0;
              end
              else
              begin
                o_sda_oe <= ~tx_ff[7];
                tx_ff    <= {tx_ff[6:0], 1'b0};
              end
            end
          ST_RACK:
            if (scl_rise && sda_s)
              state_ff <= ST_IDLE;
            else if (scl_rise)
              state_ff <= ST_AACK;
          default:
          begin
            state_ff <= ST_IDLE;
            o_sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // a change in the clearing cycle itself survives the clear
  always @*
  begin
    nxt_flag = flag_ff | change;
    nxt_ref  = ref_ff;
    if (access_ff)
    begin
      nxt_flag = edge_now;
      nxt_ref  = in_s;
    end
  end

  always @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      flag_ff       <= 4'h0;
      ref_ff        <= 4'h0;
      o_flags       <= 4'h0;
      o_int_n       <= 1'b1;
      o_mask        <= 4'h0;
      o_pullup_en   <= 4'h0;
      o_out_default <= 4'h0;
      o_addr        <= 7'h00;
      o_standby     <= 1'b0;
    end
    else if (!settled)
    begin
      // reference taken once the synchroniser holds real pin levels
      ref_ff <= in_s;
    end
    else
    begin
      flag_ff       <= nxt_flag;
      ref_ff        <= nxt_ref;
      o_flags       <= nxt_flag;
      o_int_n       <= ~(|(nxt_flag & mask4));
      o_mask        <= mask4;
      o_pullup_en   <= {{2{is_high_class(cls_hi)}}, {2{is_high_class(cls_lo)}}};
      o_out_default <= {{2{is_high_class(cls_hi)}}, {2{is_high_class(cls_lo)}}};
      o_addr        <= own_addr;
      o_standby     <= (state_ff == ST_IDLE);
    end
  end

endmodule // input_change_detect_and_reset

// File: rtl/input_change_detect_and_reset_defs.vh
// shared constants for the input change detector and its strap decoder
//
// Contract
// - reads return live synchronised pin levels
// - all four inputs flag every change
// - any addressed read or write clears flags
// - alert only for masked-in inputs, latched
// - default mask alerts on any input
// - next access releases alert and flags
// - reset clears detection and releases alert
// - mask resets to all four inputs enabled
// - flags read clear after reset
// - output defaults follow address straps
// - pullups chosen per input pair by straps
// - reset restores defaults, holds interface idle
// - bus abort forces serial idle state
// - bus abort leaves alert untouched
// - idle serial interface means standby
// - strap pairs; high/SDA/SCL mean pullup, high
// - straps re-decoded on every transmission
`ifndef INPUT_CHANGE_DETECT_AND_RESET_DEFS_VH
`define INPUT_CHANGE_DETECT_AND_RESET_DEFS_VH

// strap connection classes, chosen so the low strap maps to A1..A0 directly
`define CLS_GND      2'h0
`define CLS_VP       2'h1
`define CLS_SCL      2'h2
`define CLS_SDA      2'h3
// high strap class xor this gives A3..A2
`define AD2_XOR      2'h2
`define ADDR_TOP     3'h6

`define MASK_ALL     8'h3c
`define IN_MSB       5
`define IN_LSB       2

`define SYNC_W       9
// scl, sda and abort idle high, so no false edge after reset
`define SYNC_RST     9'h007
`define SETTLE_MAX   2'h3

`define BIT_LAST     3'h7
`define BIT_ZERO     3'h0
`define BIT_ONE      3'h1
`define BYTE_ZERO    8'h00

`endif

// File: rtl/strap_decode.v
// four-level address strap decoder for one strap pin
`timescale 1ns/100ps
`include "input_change_detect_and_reset_defs.vh"
module strap_decode
(
  input  wire       i_clk,
  input  wire       i_arst_n,
  input  wire       i_strap,
  input  wire       i_scl,
  input  wire       i_sda,
  input  wire       i_settled,
  input  wire       i_start,
  input  wire       i_stop,
  output reg  [1:0] o_cls_ff
);

  reg init_ff;
  reg xfer_ff;
  reg ne_scl_ff;
  reg ne_sda_ff;
  reg hi_ff;
  reg lo_ff;

  always @(posedge i_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_cls_ff  <= `CLS_VP;
      init_ff   <= 1'b0;
      xfer_ff   <= 1'b0;
      ne_scl_ff <= 1'b0;
      ne_sda_ff <= 1'b0;
      hi_ff     <= 1'b0;
      lo_ff     <= 1'b0;
    end
    else
    begin
      // before any transmission a bus-tied strap looks high, like the bus itself
      if (i_settled && !init_ff)
      begin
        init_ff  <= 1'b1;
        o_cls_ff <= i_strap ? `CLS_VP : `CLS_GND;
      end
      if (i_start)
      begin
        xfer_ff   <= 1'b1;
        ne_scl_ff <= 1'b0;
        ne_sda_ff <= 1'b0;
        hi_ff     <= 1'b0;
        lo_ff     <= 1'b0;
      end
      else if (xfer_ff)
      begin
        ne_scl_ff <= ne_scl_ff | (i_strap ^ i_scl);
        ne_sda_ff <= ne_sda_ff | (i_strap ^ i_sda);
        hi_ff     <= hi_ff | i_strap;
        lo_ff     <= lo_ff | ~i_strap;
        if (i_stop)
        begin
          xfer_ff <= 1'b0;
          if (!ne_scl_ff && hi_ff && lo_ff)
            o_cls_ff <= `CLS_SCL;
          else if (!ne_sda_ff && hi_ff && lo_ff)
            o_cls_ff <= `CLS_SDA;
          else if (!lo_ff)
            o_cls_ff <= `CLS_VP;
          else
            o_cls_ff <= `CLS_GND;
        end
      end
    end
  end

endmodule // strap_decode

// File: test/i2c_master_model.sv
// behavioural two-wire bus master for the expander
`timescale 1ns/100ps
module i2c_master_model
(
  input  wire  i_sda_oe,
  output logic o_scl,
  output wire  o_sda
);
  logic drv = 1'b1;
  int   slow = 0;
  // open drain with pull-up: a released line reads high
  assign o_sda = drv & ~i_sda_oe;
  initial o_scl = 1'b1;
  // long low phase: the slave lets go of its ack late after the fall
  task automatic bit_io(input logic b, output logic r);
    #6 drv = b;
    #(24 + slow) o_scl = 1'b1;
    #9 r = o_sda;
    #9 o_scl = 1'b0;
  endtask
  task automatic start;
    #24 drv = 1'b0;
    #24 o_scl = 1'b0;
  endtask
  task automatic stop;
    #6 drv = 1'b0;
    #24 o_scl = 1'b1;
    #24 drv = 1'b1;
    #24;
  endtask
  task automatic xfer(input logic [7:0] tx, input logic ack, output logic [7:0] rx,
                      output logic nak);
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(ack, nak);
  endtask
endmodule // i2c_master_model

// File: test/input_change_detect_and_reset_chk.sv
// concurrent checks on the input change detector ports
`timescale 1ns/100ps
module input_change_detect_and_reset_chk
(
  input wire       i_clk,
  input wire       i_arst_n,
  input wire       i_bus_abort_n,
  input wire [3:0] i_in,
  input wire       o_sda_oe,
  input wire       o_int_n,
  input wire [3:0] o_flags,
  input wire [3:0] o_mask,
  input wire [3:0] o_pullup_en,
  input wire [3:0] o_out_default,
  input wire [6:0] o_addr,
  input wire       o_standby
);
  logic [3:0] in_d1;
  wire  [3:0] chg = i_in ^ in_d1;
  // no reset needed: only looked at while reset is released
  always @(posedge i_clk) in_d1 <= i_in;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  sequence abort_held;
    !i_bus_abort_n [*8];
  endsequence
  sequence acked_before;
    $past(o_sda_oe);
  endsequence
  // a mask write may take one cycle to reach the alert
  chk_int_mask: assert property ($stable(o_mask) |-> o_int_n == ~|(o_flags & o_mask))
    else $error("alert disagrees with masked flags");
  chk_flag_set: assert property (|chg |-> ##5 (o_flags & $past(chg, 5)) == $past(chg, 5))
    else $error("input change left no flag");
  chk_flag_clear: assert property (|($past(o_flags) & ~o_flags) |-> acked_before)
    else $error("flag cleared without access");
  chk_int_release: assert property ($rose(o_int_n) |-> acked_before)
    else $error("alert released without access");
  chk_abort_idle: assert property (abort_held |-> o_standby && !o_sda_oe)
    else $error("abort did not idle the slave");
  chk_standby_quiet: assert property (o_standby |-> !o_sda_oe)
    else $error("data line driven in standby");
  // once an address is shown, each pair must agree with the strap class in that address
  chk_strap_pairs: assert property (o_pullup_en == o_out_default &&
    (o_addr[6:4] != 3'h6 ||
     (o_pullup_en[1:0] == {2{o_addr[1:0] != 2'h0}} &&
      o_pullup_en[3:2] == {2{o_addr[3:2] != 2'h2}})))
    else $error("pullup and default levels disagree with straps");
  chk_addr_prefix: assert property (o_standby |-> o_addr[6:4] == 3'h6)
    else $error("address prefix wrong");
endmodule // input_change_detect_and_reset_chk

bind input_change_detect_and_reset input_change_detect_and_reset_chk u_chk (
  .i_clk(i_clk), .i_arst_n(i_arst_n), .i_bus_abort_n(i_bus_abort_n), .i_in(i_in),
  .o_sda_oe(o_sda_oe), .o_int_n(o_int_n), .o_flags(o_flags), .o_mask(o_mask),
  .o_pullup_en(o_pullup_en), .o_out_default(o_out_default), .o_addr(o_addr),
  .o_standby(o_standby));

// File: test/testbench.sv
// self-checking bench for the input change detector
`timescale 1ns/100ps
module testbench;
  logic       i_clk, i_arst_n, i_bus_abort_n, s_lo, s_hi, nak, anak, tie;
  logic [3:0] i_in, ef, emask;
  logic [6:0] eaddr;
  logic [7:0] rx, d, lf;
  wire        scl, sda, oe, int_n, stby;
  wire  [3:0] flags, mask, pu, dflt;
  wire  [6:0] addr;
  wire        sda_o;
  // low strap either held at a level or wired to the bus clock
  wire        strap_lo = tie ? scl : s_lo;
  int         fail_count = 0;
  int         tests_run = 0;

  input_change_detect_and_reset u_input_change_detect_and_reset (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_scl(scl), .i_sda(sda), .o_sda_out(sda_o),
    .o_sda_oe(oe), .i_bus_abort_n(i_bus_abort_n), .i_in(i_in),
    .i_addr_strap_low(strap_lo), .i_addr_strap_high(s_hi), .o_int_n(int_n),
    .o_flags(flags), .o_mask(mask), .o_pullup_en(pu), .o_out_default(dflt),
    .o_addr(addr), .o_standby(stby));
  i2c_master_model u_master (.i_sda_oe(oe), .o_scl(scl), .o_sda(sda));

  function automatic logic [7:0] nxt(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic access(input logic [6:0] a, input logic rd, input logic [7:0] wd);
    u_master.start();
    u_master.xfer({a, rd}, 1'b1, rx, anak);
    u_master.xfer(rd ? 8'hff : wd, 1'b1, rx, nak);
    u_master.stop();
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end
  initial
  begin
    #400000;
    fail_count++;
    stop_test();
  end
  initial
  begin
    i_arst_n = 1'b0;
    i_bus_abort_n = 1'b1;
    s_lo = 1'b1;
    s_hi = 1'b0;
    tie = 1'b0;
    i_in = 4'h0;
    ef = 4'h0;
    emask = 4'hf;
    eaddr = 7'h69;
    lf = 8'h15;
    repeat (16) @(posedge i_clk);
    i_arst_n <= 1'b1;
    tick(20);
    chk(mask, 4'hf);
    chk(flags, 4'h0);
    chk(int_n, 1'b1);
    chk(stby, 1'b1);
    chk(addr, eaddr);
    chk({pu, dflt}, 8'h33);
    $display("power-up test done");
    for (int n = 0; n < 24; n++)
    begin
      lf = nxt(lf);
      d = nxt(lf);
      @(posedge i_clk) i_in <= i_in ^ lf[3:0];
      ef = ef | lf[3:0];
      // short pulse still has to leave its flag behind
      if (lf[4])
      begin
        repeat (3) @(posedge i_clk);
        i_in <= i_in ^ lf[3:0];
      end
      tick(8);
      chk(flags, ef);
      chk(int_n, ~|(ef & emask));
      if (n == 12) @(posedge i_clk) s_hi <= 1'b1;
      u_master.slow = lf[0] ? 60 : 0;
      access(lf[7:6] == 2'h0 ? eaddr ^ 7'h01 : eaddr, lf[5], d);
      tick(4);
      if (n == 12) eaddr = 7'h6d;
      if (lf[7:6] != 2'h0)
      begin
        ef = 4'h0;
        if (lf[5]) chk(rx, {2'h0, i_in, 2'h0});
        else emask = d[5:2];
      end
      chk(anak, lf[7:6] == 2'h0);
      chk(flags, ef);
      chk(int_n, ~|(ef & emask));
      chk(mask, emask);
      chk(addr, eaddr);
      chk({pu, dflt}, {s_hi, s_hi, s_lo, s_lo, s_hi, s_hi, s_lo, s_lo});
      $display("random access %0d done", n);
    end
    access(eaddr, 1'b0, 8'h3c);
    u_master.start();
    u_master.xfer({eaddr, 1'b0}, 1'b1, rx, anak);
    @(posedge i_clk) i_in <= i_in ^ 4'h1;
    tick(8);
    chk(int_n, 1'b0);
    @(posedge i_clk) i_bus_abort_n <= 1'b0;
    tick(10);
    chk(stby, 1'b1);
    @(posedge i_clk) i_bus_abort_n <= 1'b1;
    tick(4);
    chk(int_n, 1'b0);
    chk(flags, 4'h1);
    u_master.xfer(8'h00, 1'b1, rx, nak);
    u_master.stop();
    tick(4);
    chk(nak, 1'b1);
    chk(mask, 4'hf);
    $display("abort test done");
    // strap on the clock line, two-byte read with master ack in between
    @(posedge i_clk) tie <= 1'b1;
    u_master.start();
    u_master.xfer({eaddr, 1'b1}, 1'b1, rx, anak);
    u_master.xfer(8'hff, 1'b0, d, nak);
    u_master.xfer(8'hff, 1'b1, rx, nak);
    u_master.stop();
    tick(4);
    chk(anak, 1'b0);
    chk(d, {2'h0, i_in, 2'h0});
    chk(rx, {2'h0, i_in, 2'h0});
    chk(flags, 4'h0);
    chk(int_n, 1'b1);
    chk(addr, 7'h6e);
    chk({pu, dflt}, 8'hff);
    chk(sda_o, 1'b0);
    $display("strap tie test done");
    stop_test();
  end
endmodule // testbench
